// File: common/tic_defs.vh
// Constants for the triple interval counter block: I/O addresses,
// field positions, reset values, counting modes and the clock divider.
// Assumes a 12-bit I/O port address and 8-bit data.
`ifndef TIC_DEFS_VH
`define TIC_DEFS_VH

`define TIC_ADDR_W        12
`define TIC_ADDR_CNT0     12'hC9C
`define TIC_ADDR_CNT1     12'hC9D
`define TIC_ADDR_CNT2     12'hC9E
`define TIC_ADDR_CTRL     12'hC9F
`define TIC_ADDR_IRQCTL   12'hCA3
`define TIC_ADDR_IRQSTAT  12'hCA4
`define TIC_ADDR_CONFIG   12'hCA5

`define TIC_CFG_GATE2     7
`define TIC_CFG_GATE1     6
`define TIC_CFG_GATE0     5
`define TIC_CFG_CASC_N    4
`define TIC_CFG_SRC1      3
`define TIC_CFG_SRC0      2
`define TIC_CFG_RST       6'h00

`define TIC_IRQ_EN        7
`define TIC_IRQCTL_RST    8'h00
`define TIC_IRQCTL_MASK   8'hF7

`define TIC_DIV_LAST      3'h7

`define TIC_SC_READBACK   2'h3
`define TIC_RW_LATCH      2'h0
`define TIC_RW_LSB        2'h1
`define TIC_RW_MSB        2'h2
`define TIC_RW_BOTH       2'h3

`define TIC_MODE_TERM     3'h0
`define TIC_MODE_ONESHOT  3'h1
`define TIC_MODE_RATE     3'h2
`define TIC_MODE_SQUARE   3'h3
`define TIC_MODE_SWSTB    3'h4
`define TIC_MODE_HWSTB    3'h5

`endif

// File: hdl/tic_edge_sync.v
// Two-flop synchroniser with a rising-edge pulse for an external clock.
// Assumes the input may change at any time relative to clk.
`timescale 1ns/1ns
module tic_edge_sync (
	input  wire clk,
	input  wire resetn,
	input  wire din,
	output wire rise
);
	reg s1_ff;
	reg s2_ff;
	reg s3_ff;

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s1_ff <= 1'b0;
			s2_ff <= 1'b0;
			s3_ff <= 1'b0;
		end else begin
			s1_ff <= din;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	assign rise = s2_ff & ~s3_ff;
endmodule

// File: hdl/tic_counter.v
// One 16-bit interval counter with the usual control-word, count and
// latch programming model, binary counting only.
// Assumes one-cycle write/read strobes and a one-cycle count tick.
`timescale 1ns/1ns
`include "tic_defs.vh"
module tic_counter (
	input  wire       clk,
	input  wire       resetn,
	input  wire       tick,
	input  wire       gate,
	input  wire       ctrl_wr,
	input  wire       data_wr,
	input  wire       data_rd,
	input  wire [7:0] wdata,
	output wire [7:0] rdata,
	output reg        cnt_out
);
	reg [15:0] cnt_ff;
	reg [15:0] reload_ff;
	reg [15:0] latch_ff;
	reg [7:0]  lsb_ff;
	reg [2:0]  mode_ff;
	reg [1:0]  rw_ff;
	reg        bcd_ff;
	reg        wr_msb_ff;
	reg        rd_msb_ff;
	reg        latched_ff;
	reg        stat_pend_ff;
	reg        load_pend_ff;
	reg        have_cnt_ff;
	reg        armed_ff;
	reg        null_ff;
	reg        strobe_ff;
	reg        gate_q_ff;
	reg        trig_ff;

	wire [2:0]  nxt_mode = wdata[2] ? {1'b0, wdata[2:1]} : wdata[3:1];
	wire        wr_done = data_wr & ((rw_ff != `TIC_RW_BOTH) | wr_msb_ff);
	wire [15:0] wr_val = (rw_ff == `TIC_RW_LSB) ? {8'h00, wdata} :
		(rw_ff == `TIC_RW_MSB) ? {wdata, 8'h00} : {wdata, lsb_ff};
	wire        trig_mode = (mode_ff == `TIC_MODE_ONESHOT) |
		(mode_ff == `TIC_MODE_HWSTB);
	wire        per_mode = (mode_ff == `TIC_MODE_RATE) |
		(mode_ff == `TIC_MODE_SQUARE);
	wire [15:0] src = latched_ff ? latch_ff : cnt_ff;
	wire        hi_sel = (rw_ff == `TIC_RW_MSB) |
		((rw_ff == `TIC_RW_BOTH) & rd_msb_ff);

	// The BCD bit is only reported back in the status byte.
	assign rdata = stat_pend_ff ?
		{cnt_out, null_ff, rw_ff, mode_ff, bcd_ff} :
		(hi_sel ? src[15:8] : src[7:0]);

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_ff       <= 16'h0000;
			reload_ff    <= 16'h0000;
			latch_ff     <= 16'h0000;
			lsb_ff       <= 8'h00;
			mode_ff      <= 3'h0;
			rw_ff        <= 2'h0;
			bcd_ff       <= 1'b0;
			wr_msb_ff    <= 1'b0;
			rd_msb_ff    <= 1'b0;
			latched_ff   <= 1'b0;
			stat_pend_ff <= 1'b0;
			load_pend_ff <= 1'b0;
			have_cnt_ff  <= 1'b0;
			armed_ff     <= 1'b0;
			null_ff      <= 1'b1;
			strobe_ff    <= 1'b0;
			gate_q_ff    <= 1'b0;
			trig_ff      <= 1'b0;
			cnt_out      <= 1'b0;
		end else begin
			gate_q_ff <= gate;
			if (gate & ~gate_q_ff)
				trig_ff <= 1'b1;
			else if (tick)
				trig_ff <= 1'b0;
			if (ctrl_wr) begin
				if (wdata[7:6] == `TIC_SC_READBACK) begin
					if (!wdata[5] && !latched_ff) begin
						latch_ff   <= cnt_ff;
						latched_ff <= 1'b1;
					end
					if (!wdata[4])
						stat_pend_ff <= 1'b1;
				end else if (wdata[5:4] == `TIC_RW_LATCH) begin
					if (!latched_ff) begin
						latch_ff   <= cnt_ff;
						latched_ff <= 1'b1;
					end
				end else begin
					rw_ff        <= wdata[5:4];
					mode_ff      <= nxt_mode;
					bcd_ff       <= wdata[0];
					wr_msb_ff    <= 1'b0;
					rd_msb_ff    <= 1'b0;
					latched_ff   <= 1'b0;
					stat_pend_ff <= 1'b0;
					load_pend_ff <= 1'b0;
					have_cnt_ff  <= 1'b0;
					armed_ff     <= 1'b0;
					strobe_ff    <= 1'b0;
					null_ff      <= 1'b1;
					cnt_out      <= (nxt_mode != `TIC_MODE_TERM);
				end
			end else if (data_wr) begin
				if (rw_ff == `TIC_RW_BOTH)
					wr_msb_ff <= ~wr_msb_ff;
				if (!wr_msb_ff)
					lsb_ff <= wdata;
				if (wr_done) begin
					reload_ff    <= wr_val;
					load_pend_ff <= 1'b1;
					have_cnt_ff  <= 1'b1;
					null_ff      <= 1'b1;
					if (mode_ff == `TIC_MODE_TERM)
						cnt_out <= 1'b0;
				end
			end else if (data_rd) begin
				if (stat_pend_ff)
					stat_pend_ff <= 1'b0;
				else begin
					if (rw_ff == `TIC_RW_BOTH)
						rd_msb_ff <= ~rd_msb_ff;
					if ((rw_ff != `TIC_RW_BOTH) || rd_msb_ff)
						latched_ff <= 1'b0;
				end
			end
			// Counting is pure binary; the BCD bit never alters it.
			if (tick && !ctrl_wr) begin
				if (trig_mode && trig_ff && have_cnt_ff) begin
					cnt_ff       <= reload_ff;
					armed_ff     <= 1'b1;
					null_ff      <= 1'b0;
					load_pend_ff <= 1'b0;
					strobe_ff    <= 1'b0;
					cnt_out      <= (mode_ff != `TIC_MODE_ONESHOT);
				end else if (load_pend_ff && !trig_mode ||
					per_mode && trig_ff && armed_ff) begin
					cnt_ff <= (mode_ff == `TIC_MODE_SQUARE) ?
						{reload_ff[15:1], 1'b0} : reload_ff;
					armed_ff     <= 1'b1;
					null_ff      <= 1'b0;
					load_pend_ff <= 1'b0;
					if (per_mode)
						cnt_out <= 1'b1;
				end else if (per_mode && !gate) begin
					cnt_out <= 1'b1;
				end else if (armed_ff && (gate || trig_mode)) begin
					case (mode_ff)
					`TIC_MODE_TERM, `TIC_MODE_ONESHOT: begin
						cnt_ff <= cnt_ff - 16'h0001;
						if (cnt_ff == 16'h0001)
							cnt_out <= 1'b1;
					end
					`TIC_MODE_RATE: begin
						if (cnt_ff == 16'h0001) begin
							cnt_ff  <= reload_ff;
							cnt_out <= 1'b1;
						end else begin
							cnt_ff <= cnt_ff - 16'h0001;
							if (cnt_ff == 16'h0002)
								cnt_out <= 1'b0;
						end
					end
					`TIC_MODE_SQUARE: begin
						if (cnt_ff == 16'h0002) begin
							cnt_ff  <= {reload_ff[15:1], 1'b0};
							cnt_out <= ~cnt_out;
						end else
							cnt_ff <= cnt_ff - 16'h0002;
					end
					`TIC_MODE_SWSTB, `TIC_MODE_HWSTB: begin
						cnt_ff <= cnt_ff - 16'h0001;
						if (strobe_ff) begin
							cnt_out   <= 1'b1;
							strobe_ff <= 1'b0;
							armed_ff  <= 1'b0;
						end else if (cnt_ff == 16'h0001) begin
							cnt_out   <= 1'b0;
							strobe_ff <= 1'b1;
						end
					end
					default: begin
						cnt_ff <= cnt_ff;
					end
					endcase
				end
			end
		end
	end
endmodule

// File: hdl/tic_top.v
// Triple interval counter block: three counters, clock routing, cascade,
// gate levels, interrupt flags and the I/O-port register file.
// Assumes one-cycle io_wr/io_rd strobes synchronous to clk; read data
// appears on io_rdata one cycle after the strobe.
`timescale 1ns/1ns
`include "tic_defs.vh"
// Summary of operation
// - Each counter gate follows its own config bit, 5, 6 and 7.
// - Config bit 4 low cascades second and third counters into 32 bits.
// - Second counter clock is internal tick, or its external input if bit 3.
// - First counter clock is internal tick, or its external input if bit 2.
// - Three independent 16-bit counters with the standard programming model.
// - Binary counting only; BCD bit stored and read back but ignored.
// - In cascade the second counter is low half, third is high half.
// - In cascade the second counter output clocks the third counter.
// - Internal count tick is the bus clock divided by eight.
// - Each external clock input reaches only its own counter.
// - Third counter counts internal tick except in cascade mode.
// - A rising counter output sets a sticky interrupt status flag.
// - Cascade mode is the reset default.
// - First and second counter outputs drive the two connector output pins.
// - Writing one to a status bit clears it; zero leaves it.
// - Status flags update regardless of the mask bits.
// - Interrupt request needs the flag, its mask and the global enable.
module tic_top (
	input  wire                  clk,
	input  wire                  resetn,
	input  wire [`TIC_ADDR_W-1:0] io_addr,
	input  wire                  io_wr,
	input  wire                  io_rd,
	input  wire [7:0]            io_wdata,
	output reg  [7:0]            io_rdata,
	input  wire                  ext_clk_in_a,
	input  wire                  ext_clk_in_b,
	output wire                  counter_out_a,
	output wire                  counter_out_b,
	output wire                  first_counter_gate,
	output wire                  second_counter_gate,
	output wire                  third_counter_gate,
	output reg                   irq_req
);
	reg  [2:0] div_ff;
	reg        div_tick_ff;
	reg  [7:2] timer_config_reg_ff;
	reg  [7:0] irq_ctl_ff;
	reg  [2:0] irq_flag_ff;
	reg  [2:0] out_q_ff;
	wire [2:0] cnt_out;
	wire [7:0] rd0;
	wire [7:0] rd1;
	wire [7:0] rd2;
	wire       ext_rise_a;
	wire       ext_rise_b;

	wire cascade = ~timer_config_reg_ff[`TIC_CFG_CASC_N];
	wire hit_ctrl = (io_addr == `TIC_ADDR_CTRL);
	wire hit_c0 = (io_addr == `TIC_ADDR_CNT0);
	wire hit_c1 = (io_addr == `TIC_ADDR_CNT1);
	wire hit_c2 = (io_addr == `TIC_ADDR_CNT2);
	wire ctrl_wr = io_wr & hit_ctrl;
	wire rb = (io_wdata[7:6] == `TIC_SC_READBACK);
	wire [2:0] cw_sel;
	wire [2:0] tick;
	wire [2:0] rise = cnt_out & ~out_q_ff;

	assign cw_sel[0] = ctrl_wr & (rb ? io_wdata[1] : io_wdata[7:6] == 2'h0);
	assign cw_sel[1] = ctrl_wr & (rb ? io_wdata[2] : io_wdata[7:6] == 2'h1);
	assign cw_sel[2] = ctrl_wr & (rb ? io_wdata[3] : io_wdata[7:6] == 2'h2);

	// External inputs only ever reach their own counter.
	assign tick[0] = timer_config_reg_ff[`TIC_CFG_SRC0] ?
		ext_rise_a : div_tick_ff;
	assign tick[1] = timer_config_reg_ff[`TIC_CFG_SRC1] ?
		ext_rise_b : div_tick_ff;
	// The low half's rising output carries into the high half.
	assign tick[2] = cascade ? rise[1] : div_tick_ff;

	assign first_counter_gate  = timer_config_reg_ff[`TIC_CFG_GATE0];
	assign second_counter_gate = timer_config_reg_ff[`TIC_CFG_GATE1];
	assign third_counter_gate  = timer_config_reg_ff[`TIC_CFG_GATE2];
	assign counter_out_a = cnt_out[0];
	assign counter_out_b = cnt_out[1];

	tic_edge_sync u_sync_a (
		.clk    (clk),
		.resetn (resetn),
		.din    (ext_clk_in_a),
		.rise   (ext_rise_a)
	);

	tic_edge_sync u_sync_b (
		.clk    (clk),
		.resetn (resetn),
		.din    (ext_clk_in_b),
		.rise   (ext_rise_b)
	);

	tic_counter u_cnt0 (
		.clk     (clk),
		.resetn  (resetn),
		.tick    (tick[0]),
		.gate    (first_counter_gate),
		.ctrl_wr (cw_sel[0]),
		.data_wr (io_wr & hit_c0),
		.data_rd (io_rd & hit_c0),
		.wdata   (io_wdata),
		.rdata   (rd0),
		.cnt_out (cnt_out[0])
	);

	tic_counter u_cnt1 (
		.clk     (clk),
		.resetn  (resetn),
		.tick    (tick[1]),
		.gate    (second_counter_gate),
		.ctrl_wr (cw_sel[1]),
		.data_wr (io_wr & hit_c1),
		.data_rd (io_rd & hit_c1),
		.wdata   (io_wdata),
		.rdata   (rd1),
		.cnt_out (cnt_out[1])
	);

	tic_counter u_cnt2 (
		.clk     (clk),
		.resetn  (resetn),
		.tick    (tick[2]),
		.gate    (third_counter_gate),
		.ctrl_wr (cw_sel[2]),
		.data_wr (io_wr & hit_c2),
		.data_rd (io_rd & hit_c2),
		.wdata   (io_wdata),
		.rdata   (rd2),
		.cnt_out (cnt_out[2])
	);

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			div_ff      <= 3'h0;
			div_tick_ff <= 1'b0;
		end else begin
			div_ff      <= div_ff + 3'h1;
			div_tick_ff <= (div_ff == `TIC_DIV_LAST);
		end
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			timer_config_reg_ff <= `TIC_CFG_RST;
			irq_ctl_ff          <= `TIC_IRQCTL_RST;
		end else if (io_wr) begin
			// Bits 1 and 0 are not stored and read back as zero.
			if (io_addr == `TIC_ADDR_CONFIG)
				timer_config_reg_ff <= io_wdata[7:2];
			if (io_addr == `TIC_ADDR_IRQCTL)
				irq_ctl_ff <= io_wdata & `TIC_IRQCTL_MASK;
		end
	end

	// A new edge in the same cycle as a clear keeps the flag set.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			out_q_ff    <= 3'h0;
			irq_flag_ff <= 3'h0;
			irq_req     <= 1'b0;
		end else begin
			out_q_ff    <= cnt_out;
			irq_flag_ff <= rise | (irq_flag_ff &
				~({3{io_wr & (io_addr == `TIC_ADDR_IRQSTAT)}} &
				io_wdata[2:0]));
			irq_req <= irq_ctl_ff[`TIC_IRQ_EN] &
				(|(irq_flag_ff & irq_ctl_ff[2:0]));
		end
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			io_rdata <= 8'h00;
		end else if (io_rd) begin
			case (io_addr)
			`TIC_ADDR_CNT0:    io_rdata <= rd0;
			`TIC_ADDR_CNT1:    io_rdata <= rd1;
			`TIC_ADDR_CNT2:    io_rdata <= rd2;
			`TIC_ADDR_IRQCTL:  io_rdata <= irq_ctl_ff;
			`TIC_ADDR_IRQSTAT: io_rdata <= {5'h00, irq_flag_ff};
			`TIC_ADDR_CONFIG:  io_rdata <= {timer_config_reg_ff, 2'h0};
			default:           io_rdata <= 8'h00;
			endcase
		end
	end
endmodule

// File: dv/tic_top_properties.sv
// Concurrent checks on the ports of the triple interval counter block.
// Assumes one-cycle io_wr/io_rd strobes and registered outputs.
`timescale 1ns/1ns
`include "tic_defs.vh"
module tic_top_properties (
	input wire                   clk,
	input wire                   resetn,
	input wire [`TIC_ADDR_W-1:0] io_addr,
	input wire                   io_wr,
	input wire                   io_rd,
	input wire [7:0]             io_wdata,
	input wire [7:0]             io_rdata,
	input wire                   counter_out_a,
	input wire                   first_counter_gate,
	input wire                   second_counter_gate,
	input wire                   third_counter_gate,
	input wire                   irq_req
);
	reg  [3:0] ictl_ff;
	reg        cfg_seen_ff;
	wire       cfg_wr = io_wr && io_addr == `TIC_ADDR_CONFIG;
	wire       cfg_rd = io_rd && io_addr == `TIC_ADDR_CONFIG;
	wire [2:0] gates;
	assign gates = {third_counter_gate, second_counter_gate,
		first_counter_gate};
	// Shadow of the enable and mask bits, as last written.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ictl_ff <= 4'h0;
			cfg_seen_ff <= 1'h0;
		end else begin
			if (io_wr && io_addr == `TIC_ADDR_IRQCTL)
				ictl_ff <= {io_wdata[7], io_wdata[2:0]};
			if (cfg_wr)
				cfg_seen_ff <= 1'h1;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	property p_gate_wr;
		cfg_wr |=> gates == $past(io_wdata[7:5]);
	endproperty
	a_gate_wr: assert property (p_gate_wr)
		else $error("gate levels differ from config write");
	property p_gate_hold;
		!cfg_wr |=> $stable(gates);
	endproperty
	a_gate_hold: assert property (p_gate_hold)
		else $error("gate levels moved without config write");
	property p_gate_rd;
		cfg_rd |=> io_rdata[7:5] == $past(gates);
	endproperty
	a_gate_rd: assert property (p_gate_rd)
		else $error("config readback differs from gate levels");
	property p_cfg_rsv;
		cfg_rd |=> io_rdata[1:0] == 2'h0;
	endproperty
	a_cfg_rsv: assert property (p_cfg_rsv)
		else $error("config low bits read nonzero");
	property p_cfg_dflt;
		cfg_rd && !cfg_seen_ff |=> io_rdata[4:0] == 5'h00;
	endproperty
	a_cfg_dflt: assert property (p_cfg_dflt)
		else $error("config default is not cascade");
	property p_rd_hold;
		!io_rd |=> $stable(io_rdata);
	endproperty
	a_rd_hold: assert property (p_rd_hold)
		else $error("read data changed without read");
	property p_irq_en;
		irq_req |-> $past(ictl_ff[3]);
	endproperty
	a_irq_en: assert property (p_irq_en)
		else $error("irq request while disabled");
	property p_irq_mask;
		irq_req |-> $past(ictl_ff[2:0]) != 3'h0;
	endproperty
	a_irq_mask: assert property (p_irq_mask)
		else $error("irq request with all masks off");
	property p_irq_set;
		$rose(counter_out_a) && ictl_ff[3] && ictl_ff[0] |-> ##[1:3] irq_req;
	endproperty
	a_irq_set: assert property (p_irq_set)
		else $error("rising output raised no irq request");
endmodule

bind tic_top tic_top_properties u_props (.clk(clk), .resetn(resetn),
	.io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
	.io_rdata(io_rdata), .counter_out_a(counter_out_a),
	.first_counter_gate(first_counter_gate),
	.second_counter_gate(second_counter_gate),
	.third_counter_gate(third_counter_gate), .irq_req(irq_req));

// File: dv/tic_host.sv
// Host processor model driving one-cycle I/O port strobes.
// Assumes the device samples strobes on the rising clk edge.
`timescale 1ns/1ns
`include "tic_defs.vh"
module tic_host (
	input  wire                   clk,
	output reg  [`TIC_ADDR_W-1:0] io_addr,
	output reg                    io_wr,
	output reg                    io_rd,
	output reg  [7:0]             io_wdata
);
	initial begin
		io_addr = 12'h000;
		io_wr = 1'h0;
		io_rd = 1'h0;
		io_wdata = 8'h00;
	end
	// A released bus shows inverted values, never the last ones.
	task xfer(input w, input [11:0] a, input [7:0] d);
		begin
			@(posedge clk);
			#1;
			io_addr = a;
			io_wdata = (a == `TIC_ADDR_CONFIG) ? {d[7:2], 2'h0} : d;
			io_wr = w;
			io_rd = !w;
			@(posedge clk);
			#1;
			io_wr = 1'h0;
			io_rd = 1'h0;
			io_addr = ~io_addr;
			io_wdata = ~io_wdata;
		end
	endtask
	task wr(input [11:0] a, input [7:0] d);
		xfer(1'h1, a, d);
	endtask
	task rd(input [11:0] a);
		xfer(1'h0, a, 8'h00);
	endtask
endmodule

// File: dv/testbench.sv
// Self-checking bench for the triple interval counter block.
// Assumes the host model drives the bus and reads answer one cycle later.
`timescale 1ns/1ns
`include "tic_defs.vh"
module testbench;
	reg                    clk;
	reg                    resetn;
	reg                    ext_clk_in_a;
	reg                    ext_clk_in_b;
	reg                    rd_seen;
	reg  [15:0]            note;
	reg  [15:0]            exp_q[$];
	reg  [7:0]             v;
	integer                n_errors;
	integer                checked;
	integer                seed;
	integer                rnd;
	integer                i;
	integer                cyc;
	wire [`TIC_ADDR_W-1:0] io_addr;
	wire                   io_wr;
	wire                   io_rd;
	wire [7:0]             io_wdata;
	wire [7:0]             io_rdata;
	wire                   counter_out_a;
	wire                   counter_out_b;
	wire [2:0]             gate;
	wire                   irq_req;
	tic_host host (.clk(clk), .io_addr(io_addr), .io_wr(io_wr),
		.io_rd(io_rd), .io_wdata(io_wdata));
	tic_top dut (.clk(clk), .resetn(resetn), .io_addr(io_addr),
		.io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
		.io_rdata(io_rdata), .ext_clk_in_a(ext_clk_in_a),
		.ext_clk_in_b(ext_clk_in_b), .counter_out_a(counter_out_a),
		.counter_out_b(counter_out_b), .first_counter_gate(gate[0]),
		.second_counter_gate(gate[1]), .third_counter_gate(gate[2]),
		.irq_req(irq_req));
	always #20 clk = ~clk;
	// External clocks of 6 and 10 cycles, changed just after clk rises.
	always @(posedge clk) begin
		#1;
		cyc = cyc + 1;
		ext_clk_in_a = (cyc % 6) < 3;
		ext_clk_in_b = (cyc % 10) < 5;
	end
	task chk(input [47:0] name, input [7:0] e, input [7:0] g);
		begin
			checked = checked + 1;
			if (g !== e) begin
				n_errors = n_errors + 1;
				$display("MISMATCH %0s exp %h got %h", name, e, g);
			end
		end
	endtask
	task stop_test;
		begin
			$display("checked %0d n_errors %0d", checked, n_errors);
			if (n_errors == 0 && checked > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	task rd_note(input [11:0] a, input [7:0] e, input [7:0] m);
		begin
			exp_q.push_back({m, e});
			host.rd(a);
		end
	endtask
	// Cycles between two rising edges of the chosen counter output.
	task period(input sel, input [7:0] e);
		integer n;
		integer k;
		integer t0;
		reg     p;
		reg     o;
		begin
			k = 0;
			t0 = 0;
			p = 1'h1;
			for (n = 0; n < 800 && k < 2; n = n + 1) begin
				@(posedge clk);
				#2;
				o = sel ? counter_out_b : counter_out_a;
				if (o && !p) begin
					k = k + 1;
					if (k == 1)
						t0 = n;
				end
				p = o;
			end
			t0 = n - 1 - t0;
			if (k < 2) begin
				chk("rises", 8'h02, k[7:0]);
				stop_test;
			end else begin
				chk("period", e, t0[7:0]);
				chk("perhi", 8'h00, t0[15:8]);
			end
		end
	endtask
	always @(posedge clk)
		rd_seen <= io_rd;
	always @(negedge clk) begin
		if (rd_seen) begin
			note = exp_q.pop_front();
			chk("rdata", note[7:0], io_rdata & note[15:8]);
		end
	end
	initial begin
		#3000000;
		n_errors = n_errors + 1;
		stop_test;
	end
	initial begin
		clk = 1'h0;
		resetn = 1'h0;
		ext_clk_in_a = 1'h0;
		ext_clk_in_b = 1'h0;
		rd_seen = 1'h0;
		n_errors = 0;
		checked = 0;
		seed = 33;
		cyc = 0;
		repeat (3) @(posedge clk);
		#1;
		resetn = 1'h1;
		rd_note(`TIC_ADDR_CONFIG, 8'h00, 8'hFF);
		rd_note(`TIC_ADDR_IRQSTAT, 8'h00, 8'hFF);
		host.wr(12'hCA6, 8'hFF);
		rd_note(12'hCA6, 8'h00, 8'hFF);
		for (i = 0; i < 8; i = i + 1) begin
			rnd = $random(seed);
			v = {i[2:0], rnd[4:0]};
			host.wr(`TIC_ADDR_CONFIG, v);
			chk("gates", {5'h00, i[2:0]}, {5'h00, gate});
			rd_note(`TIC_ADDR_CONFIG, v & 8'hFC, 8'hFF);
		end
		host.wr(`TIC_ADDR_CTRL, 8'h35);
		host.wr(`TIC_ADDR_CNT0, 8'h10);
		host.wr(`TIC_ADDR_CNT0, 8'h00);
		host.wr(`TIC_ADDR_CTRL, 8'hE2);
		rd_note(`TIC_ADDR_CNT0, 8'h35, 8'h3F);
		host.wr(`TIC_ADDR_CONFIG, 8'h20);
		host.wr(`TIC_ADDR_IRQCTL, 8'h81);
		period(1'h0, 8'h80);
		for (i = 0; i < 400 && irq_req !== 1'h1; i = i + 1) begin
			@(posedge clk);
			#1;
		end
		chk("irq", 8'h01, {7'h00, irq_req});
		host.wr(`TIC_ADDR_IRQSTAT, 8'h00);
		rd_note(`TIC_ADDR_IRQSTAT, 8'h01, 8'h01);
		host.wr(`TIC_ADDR_IRQSTAT, 8'h01);
		rd_note(`TIC_ADDR_IRQSTAT, 8'h00, 8'h01);
		host.wr(`TIC_ADDR_IRQCTL, 8'h80);
		period(1'h0, 8'h80);
		rd_note(`TIC_ADDR_IRQSTAT, 8'h01, 8'h01);
		chk("irq", 8'h00, {7'h00, irq_req});
		host.wr(`TIC_ADDR_CONFIG, 8'h24);
		period(1'h0, 8'h60);
		host.wr(`TIC_ADDR_CTRL, 8'h74);
		host.wr(`TIC_ADDR_CNT1, 8'h04);
		host.wr(`TIC_ADDR_CNT1, 8'h00);
		host.wr(`TIC_ADDR_CONFIG, 8'h48);
		period(1'h1, 8'h28);
		host.wr(`TIC_ADDR_CONFIG, 8'h40);
		period(1'h1, 8'h20);
		for (i = 0; i < 2; i = i + 1) begin
			host.wr(`TIC_ADDR_CTRL, 8'h74);
			host.wr(`TIC_ADDR_CNT1, 8'h02);
			host.wr(`TIC_ADDR_CNT1, 8'h00);
			host.wr(`TIC_ADDR_CONFIG, i ? 8'hD0 : 8'hC0);
			host.wr(`TIC_ADDR_CTRL, 8'hB0);
			host.wr(`TIC_ADDR_CNT2, 8'h03);
			host.wr(`TIC_ADDR_CNT2, 8'h00);
			host.wr(`TIC_ADDR_IRQSTAT, 8'h07);
			repeat (40) @(posedge clk);
			rd_note(`TIC_ADDR_IRQSTAT, i ? 8'h04 : 8'h00, 8'h04);
			repeat (80) @(posedge clk);
			rd_note(`TIC_ADDR_IRQSTAT, 8'h04, 8'h04);
		end
		// Square wave on the first counter, then a strobe on the second.
		host.wr(`TIC_ADDR_CONFIG, 8'h60);
		host.wr(`TIC_ADDR_CTRL, 8'h36);
		host.wr(`TIC_ADDR_CNT0, 8'h10);
		host.wr(`TIC_ADDR_CNT0, 8'h00);
		period(1'h0, 8'h80);
		host.wr(`TIC_ADDR_CTRL, 8'h78);
		host.wr(`TIC_ADDR_CNT1, 8'h02);
		host.wr(`TIC_ADDR_CNT1, 8'h00);
		host.wr(`TIC_ADDR_IRQSTAT, 8'h07);
		repeat (60) @(posedge clk);
		rd_note(`TIC_ADDR_IRQSTAT, 8'h02, 8'h02);
		// A low gate holds the loaded count, which is latched and read.
		host.wr(`TIC_ADDR_CONFIG, 8'h00);
		host.wr(`TIC_ADDR_CTRL, 8'h30);
		host.wr(`TIC_ADDR_CNT0, 8'h34);
		host.wr(`TIC_ADDR_CNT0, 8'h12);
		repeat (10) @(posedge clk);
		host.wr(`TIC_ADDR_CTRL, 8'h00);
		rd_note(`TIC_ADDR_CNT0, 8'h34, 8'hFF);
		rd_note(`TIC_ADDR_CNT0, 8'h12, 8'hFF);
		repeat (2) @(posedge clk);
		stop_test;
	end
endmodule
